// File: sli_interlock.sv
/*
  Output-release logic of the safety sensor: start-up modes, reset button
  window, field set switchover with monitoring, fault shutdown, AXI4-Lite
  registers and a masked interrupt.
  Assumes all pins but RST_B synchronous to CLK; field occupancy is evaluated outside.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - violated active protective field turns both safety outputs off
// - automatic mode: outputs on at power-up and whenever field is clear
// - start interlock mode: outputs stay off after supply return until reset press
// - start interlock mode: later violation turns off, clear field turns back on
// - full interlock: outputs stay off after field clears and after power-up
// - full interlock: only a valid reset press re-enables the outputs
// - reset press must last between 0.12 s and 4 s
// - response time is the longest delay from violation to switch-off
// - two activation modes: fixed set, or inputs with fixed switchover time
// - fixed mode always monitors the first field set
// - switchable sets may be changed at any time via control inputs; here a change while a switchover is still running is a fault
// - active set is chosen from the control inputs
// - old set stays monitored for the switchover time
// - switch to occupied field: off after 25 ms plus switchover plus response
// - broken changeover rules: fault, outputs off, diagnostic shown
// - one detection resolution for all field sets of a bank
// - one maximum vehicle speed for all field sets of a bank
module sli_interlock
  import sli_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic CLK, // 40 MHz clock
  input wire logic RST_B, // async reset, low
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic [NUM_SETS-1:0] FIELD_OCC, // per-set field occupied
  input wire logic [SEL_W-1:0] FS_SEL, // field set control inputs
  input wire logic RESET_BTN, // reset button, high pressed
  output logic [1:0] SAFETY_OUTPUT, // both safety outputs
  output logic [SEL_W-1:0] ACTIVE_SET, // monitored field set
  output logic FAULT, // fault lock
  output logic RES_70MM, // resolution 70 mm when high
  output logic [15:0] MAX_VEHICLE_SPEED, // speed for evaluation
  output logic IRQ // level interrupt
);
  // ==========================================================
  // functions
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    reg_ok = (a == ADDR_CTRL) || (a == ADDR_SWTIME) ||
      (a == ADDR_RESP) || (a == ADDR_SPEED) || (a == ADDR_ALLOW) ||
      (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
      (a == ADDR_IRQ_MASK);
  endfunction

  // ==========================================================
  // declarations
  sli_ctrl_s ctrl;
  logic [15:0] swtime;
  logic [15:0] resp;
  logic [15:0] speed;
  logic [31:0] allow;
  logic [NUM_EV-1:0] irq_mask;
  logic [NUM_EV-1:0] irq_stat;
  logic [NUM_EV-1:0] ev;
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic do_rd;
  logic rd_clr;
  logic flt_clr;
  logic [31:0] rd_mux;
  logic [31:0] st_word;
  logic [15:0] ms_cnt;
  logic tick;
  logic btn_q;
  logic [12:0] press_cnt;
  logic press_ok;
  logic [SEL_W-1:0] sel_now;
  logic [SEL_W-1:0] target;
  logic [SEL_W-1:0] active;
  logic sw_busy;
  logic [16:0] sw_cnt;
  logic sw_done;
  logic viol;
  logic [15:0] viol_cnt;
  logic viol_conf;
  logic flt;
  logic flt_evt;
  sli_cause_e cause;
  sli_cause_e next_cause;
  sli_state_e state;
  sli_state_e next_state;

  // ==========================================================
  // AXI4-Lite slave
  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_hold && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_wr = aw_hold && w_hold && !S_AXI_BVALID;
  assign do_rd = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_clr = do_rd && (S_AXI_ARADDR == ADDR_IRQ_STAT);
  assign flt_clr = do_wr && (aw_addr == ADDR_CTRL) && w_strb[0] &&
    w_data[CTRL_FLT_CLR_BIT];

  // address and data may arrive in either order
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OK;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= reg_ok(aw_addr) ? RESP_OK : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= CTRL_RST;
      swtime <= SWTIME_RST;
      resp <= RESP_RST;
      speed <= SPEED_RST;
      allow <= ALLOW_RST;
      irq_mask <= MASK_RST;
    end else if (do_wr) begin
      if (aw_addr == ADDR_CTRL) begin
        ctrl <= sli_ctrl_s'(4'(merge({28'h0, ctrl}, w_data, w_strb)));
      end else if (aw_addr == ADDR_SWTIME) begin
        swtime <= 16'(merge({16'h0, swtime}, w_data, w_strb));
      end else if (aw_addr == ADDR_RESP) begin
        resp <= 16'(merge({16'h0, resp}, w_data, w_strb));
      end else if (aw_addr == ADDR_SPEED) begin
        speed <= 16'(merge({16'h0, speed}, w_data, w_strb));
      end else if (aw_addr == ADDR_ALLOW) begin
        allow <= merge(allow, w_data, w_strb);
      end else if (aw_addr == ADDR_IRQ_MASK) begin
        irq_mask <= NUM_EV'(merge({29'h0, irq_mask}, w_data, w_strb));
      end
    end
  end

  always_comb begin
    st_word = '0;
    st_word[ST_OUT_BIT] = (state == ST_ON);
    st_word[ST_STATE_LSB +: 4] = state;
    st_word[ST_SET_LSB +: SEL_W] = active;
    st_word[ST_VIOL_BIT] = viol;
    st_word[ST_BUSY_BIT] = sw_busy;
    st_word[ST_FLT_BIT] = flt;
    st_word[ST_CAUSE_LSB +: 2] = cause;
  end

  always_comb begin
    rd_mux = '0;
    if (S_AXI_ARADDR == ADDR_CTRL) begin
      rd_mux = {28'h0, ctrl};
    end else if (S_AXI_ARADDR == ADDR_SWTIME) begin
      rd_mux = {16'h0, swtime};
    end else if (S_AXI_ARADDR == ADDR_RESP) begin
      rd_mux = {16'h0, resp};
    end else if (S_AXI_ARADDR == ADDR_SPEED) begin
      rd_mux = {16'h0, speed};
    end else if (S_AXI_ARADDR == ADDR_ALLOW) begin
      rd_mux = allow;
    end else if (S_AXI_ARADDR == ADDR_STATUS) begin
      rd_mux = st_word;
    end else if (S_AXI_ARADDR == ADDR_IRQ_STAT) begin
      rd_mux = {29'h0, irq_stat};
    end else if (S_AXI_ARADDR == ADDR_IRQ_MASK) begin
      rd_mux = {29'h0, irq_mask};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OK;
    end else if (do_rd) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= reg_ok(S_AXI_ARADDR) ? RESP_OK : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt: sticky, cleared by read, set wins
  assign ev[EV_OFF] = (state == ST_ON) && (next_state != ST_ON);
  assign ev[EV_ON] = (state != ST_ON) && (next_state == ST_ON);
  assign ev[EV_FLT] = flt_evt;

  for (genvar g = 0; g < NUM_EV; g++) begin : g_irq
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        irq_stat[g] <= 1'b0;
      end else if (ev[g]) begin
        irq_stat[g] <= 1'b1;
      end else if (rd_clr) begin
        irq_stat[g] <= 1'b0;
      end
    end
  end
  assign IRQ = |(irq_stat & irq_mask);

  // ==========================================================
  // millisecond tick
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ms_cnt <= '0;
    end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end
  assign tick = (ms_cnt == 16'(MS_CYCLES - 1));

  // ==========================================================
  // reset button window
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      btn_q <= 1'b0;
      press_cnt <= '0;
    end else begin
      btn_q <= RESET_BTN;
      if (!RESET_BTN) begin
        press_cnt <= '0;
      end else if (tick && (press_cnt != 13'h1FFF)) begin
        press_cnt <= press_cnt + 13'h0001;
      end
    end
  end
  // window on release
  // tick granularity: one extra ms is demanded at the short end
  assign press_ok = btn_q && !RESET_BTN &&
    (press_cnt > 13'(RST_MIN_MS)) && (press_cnt < 13'(RST_MAX_MS));

  // ==========================================================
  // field set selection and switchover
  // selection source
  assign sel_now = ctrl.fs_inputs ? FS_SEL : '0;
  assign sw_done = sw_busy && tick &&
    (sw_cnt + 17'h00001 >= 17'(SYNC_MS) + {1'b0, swtime});

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      target <= '0;
      active <= '0;
      sw_busy <= 1'b0;
      sw_cnt <= '0;
    end else if (flt) begin
      sw_busy <= 1'b0;
      target <= active;
    end else if ((sel_now != target) && !flt_evt) begin
      target <= sel_now;
      sw_busy <= 1'b1;
      sw_cnt <= '0;
    end else if (sw_done) begin
      active <= target;
      sw_busy <= 1'b0;
    end else if (sw_busy && tick) begin
      sw_cnt <= sw_cnt + 17'h00001;
    end
  end

  always_comb begin
    flt_evt = 1'b0;
    next_cause = CAUSE_NONE;
    if (!flt && (sel_now != target)) begin
      if (!allow[sel_now]) begin
        flt_evt = 1'b1;
        next_cause = CAUSE_SET;
      end else if (sw_busy) begin
        flt_evt = 1'b1;
        next_cause = CAUSE_TIME;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flt <= 1'b0;
      cause <= CAUSE_NONE;
    end else if (flt_evt) begin
      flt <= 1'b1;
      cause <= next_cause;
    end else if (flt_clr) begin
      flt <= 1'b0;
      cause <= CAUSE_NONE;
    end
  end

  // ==========================================================
  // violation and response time
  assign viol = FIELD_OCC[active];
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      viol_cnt <= '0;
    end else if (!viol || sw_done) begin
      viol_cnt <= '0;
    end else if (tick && (viol_cnt != 16'hFFFF)) begin
      viol_cnt <= viol_cnt + 16'h0001;
    end
  end
  assign viol_conf = viol && (viol_cnt >= resp);

  // ==========================================================
  // start-up and restart state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_LOCK: begin
        if (flt || flt_evt) begin
          next_state = ST_FAULT;
        end else if (ctrl.start_mode == MODE_AUTO) begin
          next_state = ST_WAIT;
        end else if (press_ok && !viol) begin
          next_state = ST_ON;
        end
      end
      ST_WAIT: begin
        if (flt || flt_evt) begin
          next_state = ST_FAULT;
        end else if (!viol) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (flt_evt) begin
          next_state = ST_FAULT;
        end else if (viol_conf) begin
          if ((ctrl.start_mode == MODE_AUTO) ||
              (ctrl.start_mode == MODE_START)) begin
            next_state = ST_WAIT;
          end else begin
            next_state = ST_LOCK;
          end
        end
      end
      ST_FAULT: begin
        if (!flt) begin
          next_state = ST_LOCK;
        end
      end
      default: begin
        next_state = ST_FAULT;
      end
    endcase
  end

  // power-up lands in the locked state; auto mode leaves it next cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_LOCK;
    end else begin
      state <= next_state;
    end
  end

  assign SAFETY_OUTPUT = {2{state == ST_ON}};
  assign ACTIVE_SET = active;
  assign FAULT = flt;
  assign RES_70MM = ctrl.res70;
  assign MAX_VEHICLE_SPEED = speed;

  // ==========================================================
  // assertions
  property p_viol_off;
    @(posedge CLK) disable iff (!RST_B)
    (state == ST_ON) && viol_conf |=> (SAFETY_OUTPUT == 2'h0);
  endproperty
  a_viol_off: assert property (p_viol_off) else $error("outputs on after violation");

  property p_auto_on;
    @(posedge CLK) disable iff (!RST_B)
    (state == ST_WAIT) && !viol && !flt && !flt_evt |=> SAFETY_OUTPUT == 2'h3;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("no restart on clear");

  property p_lock;
    @(posedge CLK) disable iff (!RST_B)
    (state == ST_LOCK) && !press_ok && (ctrl.start_mode != MODE_AUTO) |=> state != ST_ON;
  endproperty
  a_lock: assert property (p_lock) else $error("release without press");

  property p_restart;
    @(posedge CLK) disable iff (!RST_B)
    (state == ST_ON) && viol_conf && !flt_evt && (ctrl.start_mode == MODE_START)
      |=> (state == ST_WAIT) ##1 ($past(viol) || state == ST_ON || flt);
  endproperty
  a_restart: assert property (p_restart) else $error("automatic restart missing");

  property p_full;
    @(posedge CLK) disable iff (!RST_B)
    (state == ST_ON) && viol_conf && !flt_evt && (ctrl.start_mode == MODE_FULL) |=> state == ST_LOCK;
  endproperty
  a_full: assert property (p_full) else $error("restart interlock missing");

  property p_press_only;
    @(posedge CLK) disable iff (!RST_B)
    $rose(SAFETY_OUTPUT[0]) && ($past(state) == ST_LOCK) |-> $past(press_ok) && $past(press_cnt) > 13'(RST_MIN_MS);
  endproperty
  a_press_only: assert property (p_press_only) else $error("release without valid press");

  property p_long_press;
    @(posedge CLK) disable iff (!RST_B)
    btn_q && !RESET_BTN && (press_cnt >= 13'(RST_MAX_MS)) |-> !press_ok;
  endproperty
  a_long_press: assert property (p_long_press) else $error("overlong press accepted");

  property p_fixed;
    @(posedge CLK) disable iff (!RST_B)
    !ctrl.fs_inputs && !sw_busy && !flt && (active == 5'h00) |=> active == 5'h00;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode left first set");

  property p_hold_old;
    @(posedge CLK) disable iff (!RST_B)
    $changed(active) |-> $past(sw_busy) && !sw_busy;
  endproperty
  a_hold_old: assert property (p_hold_old) else $error("set changed outside handover");

  property p_fault_off;
    @(posedge CLK) disable iff (!RST_B)
    flt_evt |=> flt && (SAFETY_OUTPUT == 2'h0) && (cause != CAUSE_NONE);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault without shutdown");

  c_on: cover property (@(posedge CLK) disable iff (!RST_B) $rose(SAFETY_OUTPUT[0]));
  c_fault: cover property (@(posedge CLK) disable iff (!RST_B) flt_evt);
  c_switch: cover property (@(posedge CLK) disable iff (!RST_B) sw_done);
endmodule
`default_nettype wire

// File: sli_pkg.sv
/*
  Shared constants and types of the safety output interlock: register map,
  field layouts, reset values, timing and state encodings.
  Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package sli_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int RST_MIN_MS = 120;
  localparam int RST_MAX_MS = 4000;
  localparam int SYNC_MS = 25;
  // ==========================================================
  // sizes
  localparam int NUM_SETS = 32;
  localparam int SEL_W = 5;
  localparam int ADDR_W = 8;
  localparam int NUM_EV = 3;
  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SWTIME = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RESP = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SPEED = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_ALLOW = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h1C;
  // ==========================================================
  // field positions
  localparam int CTRL_FLT_CLR_BIT = 4;
  localparam int ST_OUT_BIT = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_SET_LSB = 5;
  localparam int ST_VIOL_BIT = 10;
  localparam int ST_BUSY_BIT = 11;
  localparam int ST_FLT_BIT = 12;
  localparam int ST_CAUSE_LSB = 13;
  localparam int EV_OFF = 0;
  localparam int EV_ON = 1;
  localparam int EV_FLT = 2;
  // ==========================================================
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h2;
  localparam logic [15:0] SWTIME_RST = 16'h0000;
  localparam logic [15:0] RESP_RST = 16'h0000;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [31:0] ALLOW_RST = 32'hFFFF_FFFF;
  localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_AUTO = 2'h0,
    MODE_START = 2'h1,
    MODE_FULL = 2'h2
  } sli_mode_e;
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_SET = 2'h1,
    CAUSE_TIME = 2'h2
  } sli_cause_e;
  typedef enum logic [3:0] {
    ST_LOCK = 4'h1,
    ST_WAIT = 4'h2,
    ST_ON = 4'h4,
    ST_FAULT = 4'h8
  } sli_state_e;
  typedef struct packed {
    logic res70;
    logic fs_inputs;
    logic [1:0] start_mode;
  } sli_ctrl_s;
endpackage
`default_nettype wire

// File: sli_ctrl_model.sv
/*
  Model of the machine safety control and the reset button.
  Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sli_ctrl_model
  import sli_pkg::*;
#(
  parameter int MS = 4
) (
  input wire logic clk, // system clock
  output var logic [NUM_SETS-1:0] field_occ, // field occupied per set
  output var logic [SEL_W-1:0] fs_sel, // requested field set
  output var logic reset_btn // high while pressed
);
  initial begin
    field_occ = '0;
    fs_sel = '0;
    reset_btn = 1'b0;
  end
  // ==========================================================
  // operator and control actions
  // press held for a chosen time
  task automatic press(input int ms);
    reset_btn <= 1'b1;
    repeat (ms * MS) @(posedge clk);
    reset_btn <= 1'b0;
    @(posedge clk);
  endtask
  // only permitted sets unless a test wants a refusal
  task automatic req(input logic [SEL_W-1:0] s);
    fs_sel <= s;
  endtask
  task automatic occ(input logic [NUM_SETS-1:0] v);
    field_occ <= v;
  endtask
endmodule
`default_nettype wire

// File: sli_interlock_test.sv
/*
  Self-checking bench of the safety output interlock.
  Assumes sli_pkg and a shortened millisecond prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
module sli_interlock_test;
  import sli_pkg::*;
  localparam int MS = 4;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire logic awready, wready, bvalid, arready, rvalid, flt, irq, res70, btn;
  wire logic [1:0] bresp, rresp, so_w;
  wire logic [31:0] rdata;
  wire logic [NUM_SETS-1:0] occ;
  wire logic [SEL_W-1:0] sel, act;
  wire logic [15:0] speed;
  logic [1:0] so, resp;
  logic [SEL_W-1:0] sa;
  logic fl, iq;
  int n_fail, n_compared;
  sli_interlock #(.MS_CYCLES(MS)) u_sli_interlock (.CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .FIELD_OCC(occ), .FS_SEL(sel), .RESET_BTN(btn), .SAFETY_OUTPUT(so_w), .ACTIVE_SET(act),
    .FAULT(flt), .RES_70MM(res70), .MAX_VEHICLE_SPEED(speed), .IRQ(irq));
  sli_ctrl_model #(.MS(MS)) u_sli_ctrl_model (.clk(clk), .field_occ(occ), .fs_sel(sel), .reset_btn(btn));
  // ==========================================================
  // helpers
  // outputs taken at the falling edge, away from any update
  always @(negedge clk) begin
    so <= so_w;
    sa <= act;
    fl <= flt;
    iq <= irq;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ao, wo, bo;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bo = 1'b0;
    while (!bo) begin
      @(negedge clk);
      ao = awready;
      wo = wready;
      bo = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ao) awvalid <= 1'b0;
      if (wo) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic ok;
    logic [31:0] d;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ok = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ok = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
    end
    chk(d, e);
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // watchdog, well above the longest press sequence
  initial begin
    cyc(40000);
    n_fail++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    cyc(20);
    rst_b <= 1'b1;
    cyc(2);
    rd(ADDR_CTRL, 32'h2);
    rd(ADDR_ALLOW, 32'hFFFF_FFFF);
    chk(32'(so), 32'h0);
    wr(ADDR_SPEED, 32'h1234);
    wr(ADDR_CTRL, 32'hA);
    cyc(2);
    chk(32'(speed), 32'h1234);
    chk(32'(res70), 32'h1);
    wr(ADDR_SPEED, 32'h0000_5678, 4'h1);
    chk(32'(speed), 32'h1278);
    u_sli_ctrl_model.press(100);
    cyc(3);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.press(4100);
    cyc(3);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.press(200);
    cyc(3);
    chk(32'(so), 32'h3);
    u_sli_ctrl_model.occ(32'h1);
    cyc(3);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.occ(32'h0);
    cyc(20);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.press(200);
    cyc(3);
    chk(32'(so), 32'h3);
    for (int m = 1; m >= 0; m--) begin
      wr(ADDR_CTRL, 32'(m));
      u_sli_ctrl_model.occ(32'h1);
      cyc(3);
      chk(32'(so), 32'h0);
      u_sli_ctrl_model.occ(32'h0);
      cyc(3);
      chk(32'(so), 32'h3);
    end
    u_sli_ctrl_model.occ(32'h8);
    u_sli_ctrl_model.req(5'h03);
    cyc(40);
    chk(32'(sa), 32'h0);
    chk(32'(so), 32'h3);
    u_sli_ctrl_model.req(5'h00);
    wr(ADDR_SWTIME, 32'hA);
    wr(ADDR_CTRL, 32'h4);
    cyc(5);
    // occupied target: 25 + 10 ticks before the switch, checked 30 and 40 ticks after the request
    u_sli_ctrl_model.req(5'h03);
    cyc(120);
    chk(32'(sa), 32'h0);
    chk(32'(so), 32'h3);
    cyc(40);
    chk(32'(sa), 32'h3);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.occ(32'h0);
    wr(ADDR_IRQ_MASK, 32'h4);
    wr(ADDR_ALLOW, 32'hFFFF_FFDF);
    u_sli_ctrl_model.req(5'h05);
    cyc(3);
    chk(32'(fl), 32'h1);
    chk(32'(so), 32'h0);
    chk(32'(iq), 32'h1);
    rd(ADDR_IRQ_STAT, 32'h7);
    rd(ADDR_STATUS, 32'h0000_3070);
    cyc(2);
    chk(32'(iq), 32'h0);
    u_sli_ctrl_model.req(5'h03);
    cyc(2);
    wr(ADDR_CTRL, 32'h14);
    cyc(3);
    chk(32'(fl), 32'h0);
    rd(8'h40, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h44, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    chk(32'(so), 32'h3);
    wr(ADDR_RESP, 32'h5);
    u_sli_ctrl_model.occ(32'h8);
    cyc(12);
    chk(32'(so), 32'h3);
    cyc(16);
    chk(32'(so), 32'h0);
    u_sli_ctrl_model.req(5'h04);
    cyc(8);
    u_sli_ctrl_model.req(5'h06);
    cyc(3);
    rd(ADDR_STATUS, 32'h0000_5470);
    conclude();
  end
endmodule
`default_nettype wire
